// ### debug_command_interpreter.sv
// Debug line bit-rate detector, framer and command interpreter for the on-chip debugger.
// How it works
// R1: Host sends command then parameters; answers follow on the line, high byte first.
// R2: Code 00h answers the debugger revision, major byte then minor byte.
// R3: Code 02h answers the debugger status byte.
// R4: Sixteen-bit runtime counter counts clocks from zero and holds at all ones.
// R5: Code 03h answers the runtime counter, upper byte first.
// R6: Register write commands may overwrite the runtime counter; here they clear it.
// R7: Code 04h loads the next received byte into the debugger control byte.
// R8: Under read protection the debug mode bit can be set but never cleared.
// R9: Code 05h answers the debugger control byte.
// R10: Code 06h takes a two-byte program counter, dropped outside debug or when protected.
// R11: Code 07h answers the program counter, or all ones when not permitted.
// R12: Code 08h takes address high nibble, address low, size, then data bytes.
// R13: Size zero means 256; data bytes go to successive register addresses.
// R14: Outside debug mode register write bytes are consumed and discarded.
// R15: Under read protection only flash control registers may be written.
// R16: Under read protection the flash command register accepts only mass erase.
// R17: Read protection disables program counter access and other protected commands.
// R18: Outside debug mode only revision, status and control byte commands are serviced; here program counter read also answers, with all ones.
// R19: Reserved codes produce no answer and change nothing.
// R20: Each byte is one low start bit, eight bits LSB first, one high stop bit.
// R21: First byte after reset is 80h; its eight low bits set the bit period.
// R22: Break, framing error or collision aborts, sends a 40-bit break, re-detects rate.
module debug_command_interpreter #(
  parameter logic [11:0] FLASH_CTL_FIRST = 12'hff8,
  parameter logic [11:0] FLASH_CTL_LAST = 12'hfff,
  parameter logic [11:0] FLASH_CMD_ADDR = 12'hff8,
  parameter logic [7:0] MASS_ERASE_CODE = 8'h95
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Open-drain debug line
  input wire logic i_line,
  output logic o_line,
  output logic o_line_oe,
  // CPU and option side
  input wire logic i_read_protect,
  input wire logic [15:0] i_pc,
  output logic [7:0] o_ctl,
  output logic o_debug_mode,
  output logic o_ctl_wr,
  // Program counter and register file writes
  output logic o_pc_wr,
  output logic [15:0] o_pc_data,
  output logic o_reg_wr,
  output logic [11:0] o_reg_addr,
  output logic [7:0] o_reg_data
);

  typedef struct packed {
    logic [1:0] sync;
    logic line_prev;
    debug_pkg::link_t link;
    logic [9:0] bit_len;
    logic [15:0] rtimer;
    logic [3:0] rbit;
    logic [7:0] rshift;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic [15:0] low_cnt;
    debug_pkg::tx_t tx;
    logic [15:0] ttimer;
    logic [3:0] tbit;
    logic [9:0] tshift;
    logic line_oe;
    logic line_out;
    debug_pkg::cmd_t cmd;
    logic [7:0] opcode;
    logic [1:0] pidx;
    logic [8:0] remain;
    logic [11:0] cursor;
    logic [15:0] resp;
    logic [1:0] resp_left;
    logic [7:0] ctl;
    logic ctl_wr;
    logic [15:0] runtime;
    logic [15:0] pc_data;
    logic pc_wr;
    logic [11:0] reg_addr;
    logic [7:0] reg_data;
    logic reg_wr;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic err;
  logic buf_push;
  logic buf_ready;
  logic buf_valid;
  logic buf_pop_ok;
  logic [7:0] buf_data;

  assign buf_push = (s_q.cmd == debug_pkg::CMD_SEND) && (s_q.resp_left != 2'h0);
  assign buf_pop_ok = (s_q.tx == debug_pkg::TX_IDLE) && (s_q.link == debug_pkg::L_IDLE);

  resp_buffer #(.WIDTH(debug_pkg::BYTE_W)) u_resp_buffer (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_flush(err),
    .i_in_valid(buf_push),
    .o_in_ready(buf_ready),
    .i_in_data(s_q.resp[15:8]),
    .o_out_valid(buf_valid),
    .i_out_ready(buf_pop_ok),
    .o_out_data(buf_data)
  );

  always_comb begin
    logic line;
    logic debug;
    logic permit;
    logic flash_ok;
    logic [7:0] b;
    logic [15:0] half;
    logic [15:0] reload;
    logic [15:0] brk_len;
    line = s_q.sync[1];
    debug = s_q.ctl[debug_pkg::DEBUG_MODE_BIT];
    permit = debug && !i_read_protect;
    b = s_q.rx_byte;
    half = {7'h00, s_q.bit_len[9:1]};
    reload = 16'(s_q.bit_len) - 16'h0001;
    brk_len = 16'(s_q.bit_len) * 16'(debug_pkg::BREAK_BITS);
    flash_ok = (s_q.cursor >= FLASH_CTL_FIRST) && (s_q.cursor <= FLASH_CTL_LAST) &&
               ((s_q.cursor != FLASH_CMD_ADDR) || (b == MASS_ERASE_CODE));
    s_d = s_q;
    err = 1'b0;
    s_d.sync = {s_q.sync[0], i_line};
    s_d.line_prev = line;
    s_d.rx_valid = 1'b0;
    s_d.ctl_wr = 1'b0;
    s_d.pc_wr = 1'b0;
    s_d.reg_wr = 1'b0;
    s_d.line_out = 1'b0;

    // Receiver: the line is half duplex, so our own transmission is never sampled.
    s_d.low_cnt = (line || s_q.tx != debug_pkg::TX_IDLE) ? 16'h0000 : s_q.low_cnt + 16'h0001;
    unique case (s_q.link)
      debug_pkg::L_HUNT: begin
        if (s_q.line_prev && !line) begin
          s_d.link = debug_pkg::L_MEASURE;
          s_d.rtimer = 16'h0001;
        end
      end
      debug_pkg::L_MEASURE: begin
        if (line) begin
          s_d.bit_len = 10'(s_q.rtimer >> debug_pkg::AUTOBAUD_SHIFT); // [R21]
          s_d.link = (s_q.rtimer >= debug_pkg::MEASURE_MIN && s_q.rtimer <= debug_pkg::MEASURE_MAX) ?
                     debug_pkg::L_IDLE : debug_pkg::L_HUNT;
        end else if (s_q.rtimer != debug_pkg::ALL_ONES) begin
          s_d.rtimer = s_q.rtimer + 16'h0001;
        end
      end
      debug_pkg::L_IDLE: begin
        if (s_q.tx == debug_pkg::TX_IDLE && s_q.line_prev && !line) begin
          s_d.link = debug_pkg::L_FRAME;
          s_d.rtimer = half;
          s_d.rbit = 4'h0;
        end
      end
      debug_pkg::L_FRAME: begin
        if (s_q.rtimer != 16'h0000) begin
          s_d.rtimer = s_q.rtimer - 16'h0001;
        end else if (s_q.rbit == 4'h0 && line) begin
          s_d.link = debug_pkg::L_IDLE;
        end else if (s_q.rbit == debug_pkg::FRAME_STOP) begin
          s_d.link = debug_pkg::L_IDLE;
          if (!line) begin
            err = 1'b1; // [R22]
          end else begin
            s_d.rx_valid = 1'b1;
            s_d.rx_byte = s_q.rshift;
          end
        end else begin
          if (s_q.rbit != 4'h0) begin
            s_d.rshift = {line, s_q.rshift[7:1]}; // [R20]
          end
          s_d.rbit = s_q.rbit + 4'h1;
          s_d.rtimer = reload;
        end
      end
      debug_pkg::L_RECOVER: begin
        if (s_q.tx == debug_pkg::TX_IDLE && line) begin
          s_d.link = debug_pkg::L_HUNT;
          s_d.bit_len = '0;
        end
      end
    endcase
    // A break must outlast nine bit times; a zero byte is low for exactly nine and is not a break.
    if ((s_q.link == debug_pkg::L_IDLE || s_q.link == debug_pkg::L_FRAME) &&
        !line && s_q.low_cnt == brk_len) begin
      err = 1'b1; // [R22]
    end

    // Transmitter drives the line low for zero bits and releases it for ones.
    unique case (s_q.tx)
      debug_pkg::TX_IDLE: begin
        s_d.line_oe = 1'b0;
        if (buf_valid && buf_pop_ok) begin
          s_d.tx = debug_pkg::TX_SHIFT;
          s_d.tshift = {1'b1, buf_data, 1'b0}; // [R20]
          s_d.tbit = 4'h0;
          s_d.ttimer = reload;
          s_d.line_oe = 1'b1;
        end
      end
      debug_pkg::TX_SHIFT: begin
        if (s_q.ttimer == half && s_q.tshift[0] && !line) begin
          err = 1'b1; // [R22]
        end
        if (s_q.ttimer != 16'h0000) begin
          s_d.ttimer = s_q.ttimer - 16'h0001;
        end else if (s_q.tbit == debug_pkg::FRAME_STOP) begin
          s_d.tx = debug_pkg::TX_IDLE;
          s_d.line_oe = 1'b0;
        end else begin
          s_d.tshift = {1'b1, s_q.tshift[9:1]};
          s_d.tbit = s_q.tbit + 4'h1;
          s_d.ttimer = reload;
          s_d.line_oe = !s_q.tshift[1];
        end
      end
      debug_pkg::TX_BREAK: begin
        if (s_q.ttimer != 16'h0000) begin
          s_d.ttimer = s_q.ttimer - 16'h0001;
        end else begin
          s_d.tx = debug_pkg::TX_IDLE;
          s_d.line_oe = 1'b0;
        end
      end
    endcase

    // Runtime counter freezes in debug mode and restarts when debug mode is left.
    if (!debug && s_q.runtime != debug_pkg::RUNTIME_MAX) begin
      s_d.runtime = s_q.runtime + 16'h0001; // [R4]
    end

    // Command decoder.
    unique case (s_q.cmd)
      debug_pkg::CMD_WAIT: begin
        if (s_q.rx_valid) begin
          s_d.opcode = b;
          s_d.pidx = debug_pkg::PIDX_ADDR_HI;
          unique case (b)
            debug_pkg::CMD_REV: begin
              s_d.resp = debug_pkg::REVISION; // [R2]
              s_d.resp_left = 2'h2;
              s_d.cmd = debug_pkg::CMD_SEND;
            end
            debug_pkg::CMD_STAT: begin
              s_d.resp = {debug_pkg::ZERO_BYTE, debug_pkg::ZERO_BYTE};
              s_d.resp[8 + debug_pkg::STAT_DEBUG_BIT] = debug; // [R3]
              s_d.resp[8 + debug_pkg::STAT_PROTECT_BIT] = i_read_protect;
              s_d.resp_left = 2'h1;
              s_d.cmd = debug_pkg::CMD_SEND;
            end
            debug_pkg::CMD_RUNTIME: begin
              if (debug) begin
                s_d.resp = s_q.runtime; // [R5] [R18]
                s_d.resp_left = 2'h2;
                s_d.cmd = debug_pkg::CMD_SEND;
              end
            end
            debug_pkg::CMD_CTL_RD: begin
              s_d.resp = {s_q.ctl, debug_pkg::ZERO_BYTE}; // [R9]
              s_d.resp_left = 2'h1;
              s_d.cmd = debug_pkg::CMD_SEND;
            end
            debug_pkg::CMD_PC_RD: begin
              s_d.resp = permit ? i_pc : debug_pkg::ALL_ONES; // [R11] [R17]
              s_d.resp_left = 2'h2;
              s_d.cmd = debug_pkg::CMD_SEND;
            end
            debug_pkg::CMD_REG_WR: begin
              s_d.runtime = 16'h0000; // [R6]
              s_d.cmd = debug_pkg::CMD_PARAM;
            end
            debug_pkg::CMD_CTL_WR, debug_pkg::CMD_PC_WR: begin
              s_d.cmd = debug_pkg::CMD_PARAM; // [R1]
            end
            default: begin
              s_d.opcode = s_q.opcode; // [R19]
            end
          endcase
        end
      end
      debug_pkg::CMD_PARAM: begin
        if (s_q.rx_valid) begin
          s_d.pidx = s_q.pidx + 2'h1;
          unique case (s_q.opcode)
            debug_pkg::CMD_CTL_WR: begin
              s_d.ctl = b; // [R7]
              if (i_read_protect && debug) begin
                s_d.ctl[debug_pkg::DEBUG_MODE_BIT] = 1'b1; // [R8]
              end
              s_d.ctl_wr = 1'b1;
              s_d.cmd = debug_pkg::CMD_WAIT;
            end
            debug_pkg::CMD_PC_WR: begin
              if (s_q.pidx == debug_pkg::PIDX_ADDR_HI) begin
                s_d.pc_data[15:8] = b; // [R10]
              end else begin
                s_d.pc_data[7:0] = b;
                s_d.pc_wr = permit; // [R10] [R17]
                s_d.cmd = debug_pkg::CMD_WAIT;
              end
            end
            default: begin
              unique case (s_q.pidx)
                debug_pkg::PIDX_ADDR_HI: s_d.cursor[11:8] = b[3:0]; // [R12]
                debug_pkg::PIDX_ADDR_LO: s_d.cursor[7:0] = b;
                debug_pkg::PIDX_SIZE: s_d.remain = (b == debug_pkg::ZERO_BYTE) ? debug_pkg::SIZE_FULL : {1'b0, b}; // [R13]
                debug_pkg::PIDX_DATA: begin
                  s_d.pidx = debug_pkg::PIDX_DATA;
                  s_d.reg_addr = s_q.cursor;
                  s_d.reg_data = b;
                  s_d.reg_wr = debug && (!i_read_protect || flash_ok); // [R14] [R15] [R16]
                  s_d.cursor = s_q.cursor + 12'h001; // [R13]
                  s_d.remain = s_q.remain - 9'h001;
                  if (s_q.remain == 9'h001) begin
                    s_d.cmd = debug_pkg::CMD_WAIT;
                  end
                end
              endcase
            end
          endcase
        end
      end
      debug_pkg::CMD_SEND: begin
        if (buf_ready) begin
          s_d.resp = s_q.resp << debug_pkg::BYTE_W; // [R1]
          s_d.resp_left = s_q.resp_left - 2'h1;
          if (s_q.resp_left == 2'h1) begin
            s_d.cmd = debug_pkg::CMD_WAIT;
          end
        end
      end
    endcase
    if (s_q.ctl[debug_pkg::DEBUG_MODE_BIT] && !s_d.ctl[debug_pkg::DEBUG_MODE_BIT]) begin
      s_d.runtime = 16'h0000; // [R4]
    end

    // Any line error ends the command and answers with a long break.
    if (err) begin
      s_d.link = debug_pkg::L_RECOVER; // [R22]
      s_d.tx = debug_pkg::TX_BREAK;
      s_d.ttimer = 16'(s_q.bit_len) * 16'(debug_pkg::ERR_BREAK_BITS) - 16'h0001;
      s_d.line_oe = 1'b1;
      s_d.cmd = debug_pkg::CMD_WAIT;
      s_d.resp_left = 2'h0;
      s_d.rx_valid = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
      s_q.sync <= 2'h3;
      s_q.line_prev <= 1'b1;
      s_q.link <= debug_pkg::L_HUNT;
      s_q.tx <= debug_pkg::TX_IDLE;
      s_q.cmd <= debug_pkg::CMD_WAIT;
      s_q.ctl <= debug_pkg::CTL_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_line = s_q.line_out;
  assign o_line_oe = s_q.line_oe;
  assign o_ctl = s_q.ctl;
  assign o_debug_mode = s_q.ctl[debug_pkg::DEBUG_MODE_BIT];
  assign o_ctl_wr = s_q.ctl_wr;
  assign o_pc_wr = s_q.pc_wr;
  assign o_pc_data = s_q.pc_data;
  assign o_reg_wr = s_q.reg_wr;
  assign o_reg_addr = s_q.reg_addr;
  assign o_reg_data = s_q.reg_data;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  rev_answer_a: assert property ( // [R2]
    s_q.rx_valid && s_q.cmd == debug_pkg::CMD_WAIT && s_q.rx_byte == debug_pkg::CMD_REV && !err
    |=> s_q.resp == debug_pkg::REVISION && s_q.resp_left == 2'h2) else $error("revision answer wrong");
  runtime_hold_a: assert property ( // [R4]
    s_q.runtime == debug_pkg::RUNTIME_MAX && o_debug_mode == $past(o_debug_mode) && !$past(o_debug_mode)
    |-> $past(s_q.runtime) == debug_pkg::RUNTIME_MAX || $past(s_q.runtime) == 16'hfffe) else $error("runtime wrapped");
  protect_mode_a: assert property ( // [R8]
    i_read_protect && o_debug_mode |=> o_debug_mode) else $error("debug mode cleared under protection");
  pc_write_gate_a: assert property ( // [R10]
    o_pc_wr |-> $past(o_debug_mode) && !$past(i_read_protect)) else $error("program counter write not permitted");
  pc_read_mask_a: assert property ( // [R11]
    s_q.rx_valid && s_q.cmd == debug_pkg::CMD_WAIT && s_q.rx_byte == debug_pkg::CMD_PC_RD && !err
    && (!o_debug_mode || i_read_protect) |=> s_q.resp == debug_pkg::ALL_ONES) else $error("program counter leaked");
  size_zero_a: assert property ( // [R13]
    s_q.rx_valid && s_q.cmd == debug_pkg::CMD_PARAM && s_q.opcode == debug_pkg::CMD_REG_WR
    && s_q.pidx == debug_pkg::PIDX_SIZE && s_q.rx_byte == 8'h00 && !err
    |=> s_q.remain == debug_pkg::SIZE_FULL) else $error("size zero not taken as 256");
  reg_write_gate_a: assert property ( // [R14]
    o_reg_wr |-> $past(o_debug_mode)) else $error("register write outside debug mode");
  protect_flash_a: assert property ( // [R15]
    o_reg_wr && $past(i_read_protect) |-> o_reg_addr >= FLASH_CTL_FIRST && o_reg_addr <= FLASH_CTL_LAST)
    else $error("protected write outside flash control");
  mass_erase_a: assert property ( // [R16]
    o_reg_wr && $past(i_read_protect) && o_reg_addr == FLASH_CMD_ADDR |-> o_reg_data == MASS_ERASE_CODE)
    else $error("protected flash command not mass erase");
  error_break_a: assert property ( // [R22]
    err && s_q.bit_len != 10'h000 |=> s_q.tx == debug_pkg::TX_BREAK && o_line_oe [*8]) else $error("no break after error");

endmodule

// ### debug_command_interpreter_bench.sv
// Self-checking bench for the debug command interpreter and its serial host.
module debug_command_interpreter_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_read_protect = 1'b0;
  logic [15:0] i_pc = 16'h0000;
  logic line_w, pull, o_line, o_line_oe, o_debug_mode, o_ctl_wr, o_pc_wr, o_reg_wr;
  logic [7:0] o_ctl, o_reg_data;
  logic [15:0] o_pc_data, pc_seen;
  logic [11:0] o_reg_addr;
  logic [19:0] wr_q[$];
  int bad_count = 0;
  int checks_done = 0;
  int pc_cnt = 0;
  int ctl_cnt = 0;
  // The wire is low while either side pulls, otherwise the pull-up holds it high.
  assign line_w = !(pull || (o_line_oe && !o_line));
  initial forever #50 i_clk = !i_clk;
  debug_host host (.i_clk(i_clk), .i_line(line_w), .o_pull(pull));
  debug_command_interpreter uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_line(line_w), .o_line(o_line),
    .o_line_oe(o_line_oe), .i_read_protect(i_read_protect), .i_pc(i_pc), .o_ctl(o_ctl),
    .o_debug_mode(o_debug_mode), .o_ctl_wr(o_ctl_wr), .o_pc_wr(o_pc_wr), .o_pc_data(o_pc_data),
    .o_reg_wr(o_reg_wr), .o_reg_addr(o_reg_addr), .o_reg_data(o_reg_data));
  always @(posedge i_clk) begin
    if (o_pc_wr === 1'b1) begin
      pc_cnt++;
      pc_seen = o_pc_data;
    end
    if (o_reg_wr === 1'b1) wr_q.push_back({o_reg_addr, o_reg_data});
    if (o_ctl_wr === 1'b1) ctl_cnt++;
  end
  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic snd(input logic [7:0] b);
    host.send_byte(b);
  endtask
  task automatic idle();
    repeat (10) @(negedge i_clk);
  endtask
  // A count of zero means the device must stay silent.
  task automatic ask(input string what, input logic [7:0] cmd, input int n, input logic [15:0] exp);
    logic [7:0] b;
    logic got;
    snd(cmd);
    if (n == 0) begin
      host.recv_byte(b, got);
      chk(what, 20'h0, {19'h0, got});
    end
    for (int i = n; i > 0; i--) begin
      host.recv_byte(b, got);
      chk(what, 20'((exp >> (8 * (i - 1))) & 16'h00ff), {12'h0, b});
    end
  endtask
  task automatic ctlw(input logic [7:0] v);
    snd(debug_pkg::CMD_CTL_WR);
    snd(v);
    idle();
  endtask
  task automatic pcw();
    snd(debug_pkg::CMD_PC_WR);
    snd(8'hab);
    snd(8'hcd);
    idle();
  endtask
  task automatic regw(input logic [11:0] a, input logic [7:0] n, input logic [7:0] d);
    wr_q.delete();
    snd(debug_pkg::CMD_REG_WR);
    snd({4'h0, a[11:8]});
    snd(a[7:0]);
    snd(n);
    for (int i = 0; i < n; i++) snd(d + 8'(i));
    idle();
  endtask
  task automatic t_normal();
    ask("rev", debug_pkg::CMD_REV, 2, debug_pkg::REVISION);
    ask("stat", debug_pkg::CMD_STAT, 1, 16'h0000);
    ask("runtime", debug_pkg::CMD_RUNTIME, 0, 16'h0000);
    ask("reserved", 8'h01, 0, 16'h0000);
    ask("pc", debug_pkg::CMD_PC_RD, 2, 16'hffff);
    pcw();
    chk("pc writes", 20'h0, 20'(pc_cnt));
    regw(12'h020, 8'h01, 8'h5a);
    chk("reg writes", 20'h0, 20'(wr_q.size()));
  endtask
  // The register write in t_normal restarts the counter, so waiting past its range makes it saturate.
  task automatic t_enter();
    repeat (66000) @(negedge i_clk);
    ctlw(8'h80);
    chk("ctl", 20'h80, {12'h0, o_ctl});
    chk("ctl writes", 20'h1, 20'(ctl_cnt));
    chk("debug", 20'h1, {19'h0, o_debug_mode});
    ask("ctl rd", debug_pkg::CMD_CTL_RD, 1, 16'h0080);
    ask("runtime", debug_pkg::CMD_RUNTIME, 2, debug_pkg::RUNTIME_MAX);
    ask("stat", debug_pkg::CMD_STAT, 1, 16'h0080);
  endtask
  task automatic t_debug();
    @(negedge i_clk);
    i_pc = 16'h1234;
    ask("pc", debug_pkg::CMD_PC_RD, 2, 16'h1234);
    pcw();
    chk("pc writes", 20'h1, 20'(pc_cnt));
    chk("pc data", 20'habcd, {4'h0, pc_seen});
    regw(12'hfff, 8'h02, 8'h11);
    chk("reg writes", 20'h2, 20'(wr_q.size()));
    chk("reg 0", 20'hfff11, wr_q[0]);
    chk("reg 1", 20'h00012, wr_q[1]);
  endtask
  // A size of zero keeps the write open past two bytes; a break then aborts it and keeps the control byte.
  task automatic t_break();
    logic [7:0] b;
    logic got;
    regw(12'h020, 8'h00, 8'h00);
    snd(8'h77);
    snd(8'h78);
    idle();
    chk("reg writes", 20'h2, 20'(wr_q.size()));
    host.hold_low(96);
    host.recv_byte(b, got);
    chk("break", 20'h1, {19'h0, got});
    repeat (300) @(negedge i_clk);
    snd(8'h80);
    repeat (20) @(negedge i_clk);
    ask("ctl kept", debug_pkg::CMD_CTL_RD, 1, 16'h0080);
  endtask
  task automatic t_protect();
    @(negedge i_clk);
    i_read_protect = 1'b1;
    ask("stat", debug_pkg::CMD_STAT, 1, 16'h00c0);
    ctlw(8'h00);
    chk("debug", 20'h1, {19'h0, o_debug_mode});
    ask("pc", debug_pkg::CMD_PC_RD, 2, 16'hffff);
    pcw();
    chk("pc writes", 20'h1, 20'(pc_cnt));
    regw(12'h020, 8'h01, 8'h55);
    chk("reg writes", 20'h0, 20'(wr_q.size()));
    regw(12'hff8, 8'h01, 8'h95);
    chk("reg writes", 20'h1, 20'(wr_q.size()));
    chk("reg 0", 20'hff895, wr_q[0]);
    regw(12'hff8, 8'h01, 8'h12);
    chk("reg writes", 20'h0, 20'(wr_q.size()));
    @(negedge i_clk);
    i_read_protect = 1'b0;
    ctlw(8'h00);
    chk("debug", 20'h0, {19'h0, o_debug_mode});
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #9000000;
    bad_count++;
    wrap_up();
  end
  initial begin
    repeat (10) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_clk);
    snd(8'h80);
    repeat (20) @(negedge i_clk);
    t_normal();
    t_enter();
    t_debug();
    t_break();
    t_protect();
    wrap_up();
  end
endmodule

// ### debug_host.sv
// Behavioural debug host that frames bytes on the open-drain debug line.
module debug_host #(
  parameter int BIT = 8
) (
  input wire logic i_clk,
  input wire logic i_line,
  output logic o_pull
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_pull = 1'b0;
  // The stop wait is one clock short, so an answer that starts right after the stop sample is not missed.
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(negedge i_clk);
    for (int i = 0; i < 10; i++) begin
      o_pull = !f[i];
      repeat ((i == 9) ? BIT - 1 : BIT) @(negedge i_clk);
    end
  endtask
  task automatic recv_byte(output logic [7:0] b, output logic got);
    b = 8'h00;
    got = 1'b0;
    for (int n = 0; n < 40 * BIT && !got; n++) begin
      @(negedge i_clk);
      got = !i_line;
    end
    if (got) begin
      repeat (BIT / 2) @(negedge i_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(negedge i_clk);
        b[i] = i_line;
      end
      // Wait out the whole stop bit, since the device ignores a start edge while it still sends.
      repeat (BIT + BIT / 2) @(negedge i_clk);
    end
  endtask
  // Pulls the line low for a number of clocks, long enough to be taken as a break.
  task automatic hold_low(input int n);
    @(negedge i_clk);
    o_pull = 1'b1;
    repeat (n) @(negedge i_clk);
    o_pull = 1'b0;
  endtask
endmodule

// ### debug_pkg.sv
// Shared constants, command codes and state encodings for the debug command interpreter.
package debug_pkg;

  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int BIT_LEN_W = 10;
  localparam int CNT_W = 16;

  // Command codes carried in the first byte of every command.
  localparam logic [7:0] CMD_REV = 8'h00;
  localparam logic [7:0] CMD_STAT = 8'h02;
  localparam logic [7:0] CMD_RUNTIME = 8'h03;
  localparam logic [7:0] CMD_CTL_WR = 8'h04;
  localparam logic [7:0] CMD_CTL_RD = 8'h05;
  localparam logic [7:0] CMD_PC_WR = 8'h06;
  localparam logic [7:0] CMD_PC_RD = 8'h07;
  localparam logic [7:0] CMD_REG_WR = 8'h08;

  // Revision value is arbitrary; major byte first on the line.
  localparam logic [15:0] REVISION = 16'h0100;
  localparam logic [15:0] ALL_ONES = 16'hffff;
  localparam logic [15:0] RUNTIME_MAX = 16'hffff;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int DEBUG_MODE_BIT = 7;
  localparam int STAT_DEBUG_BIT = 7;
  localparam int STAT_PROTECT_BIT = 6;

  // Register write framing: two address bytes, size byte, then data.
  localparam logic [1:0] PIDX_ADDR_HI = 2'h0;
  localparam logic [1:0] PIDX_ADDR_LO = 2'h1;
  localparam logic [1:0] PIDX_SIZE = 2'h2;
  localparam logic [1:0] PIDX_DATA = 2'h3;
  localparam logic [8:0] SIZE_FULL = 9'h100;

  // Bit-rate detection: eight low bits measured, bit period between 4 and 512 clocks.
  localparam int AUTOBAUD_SHIFT = 3;
  localparam logic [15:0] MEASURE_MIN = 16'h0020;
  localparam logic [15:0] MEASURE_MAX = 16'h1000;
  localparam int BREAK_BITS = 9;
  localparam int ERR_BREAK_BITS = 40;
  localparam logic [3:0] FRAME_STOP = 4'h9;

  typedef enum logic [4:0] {
    L_HUNT = 5'b00001,
    L_MEASURE = 5'b00010,
    L_IDLE = 5'b00100,
    L_FRAME = 5'b01000,
    L_RECOVER = 5'b10000
  } link_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SHIFT = 3'b010,
    TX_BREAK = 3'b100
  } tx_t;

  typedef enum logic [2:0] {
    CMD_WAIT = 3'b001,
    CMD_PARAM = 3'b010,
    CMD_SEND = 3'b100
  } cmd_t;

endpackage

// ### resp_buffer.sv
// Two-entry response buffer between the command decoder and the line transmitter.
module resp_buffer #(
  parameter int WIDTH = debug_pkg::BYTE_W
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_flush,
  // Filling side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Draining side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);

  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
  } buf_t;

  buf_t s_q;
  buf_t s_d;
  logic push;
  logic pop;

  assign o_in_ready = (s_q.count != 2'h2);
  assign o_out_valid = (s_q.count != 2'h0);
  assign o_out_data = s_q.mem[s_q.rd_ptr];

  always_comb begin
    s_d = s_q;
    push = i_in_valid && o_in_ready;
    pop = o_out_valid && i_out_ready;
    if (push) begin
      s_d.mem[s_q.wr_ptr] = i_in_data;
      s_d.wr_ptr = !s_q.wr_ptr;
    end
    if (pop) begin
      s_d.rd_ptr = !s_q.rd_ptr;
    end
    s_d.count = s_q.count + 2'(push) - 2'(pop);
    // A flush after a line error drops any queued answer.
    if (i_flush) begin
      s_d.wr_ptr = 1'b0;
      s_d.rd_ptr = 1'b0;
      s_d.count = 2'h0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule
